// ===== hdl/sla_animator.sv
// Segment LCD animation unit: pattern arrays, shifting and segment muxing
`timescale 1ns/1ps
module sla_animator
   import sla_pkg::*;
#(
   parameter int ANIM_WIDTH = SLA_ANIM_WIDTH,
   parameter int SEG_COUNT  = SLA_SEG_COUNT
)(
   input  wire logic                  CLK,
   input  wire logic                  ARST_N,
   input  wire logic                  FRAME_TICK,
   input  wire sla_ctrl_s             CTRL,
   input  wire logic [ANIM_WIDTH-1:0] PATTERN_FIRST_DATA,
   input  wire logic                  PATTERN_FIRST_WE,
   input  wire logic [ANIM_WIDTH-1:0] PATTERN_SECOND_DATA,
   input  wire logic                  PATTERN_SECOND_WE,
   input  wire logic [SEG_COUNT-1:0]  SEG_DATA,
   output logic [SEG_COUNT-1:0]       SEG_OUT,
   output logic [ANIM_WIDTH-1:0]      PATTERN_FIRST,
   output logic [ANIM_WIDTH-1:0]      PATTERN_SECOND
);

   logic                  overflow;
   logic [ANIM_WIDTH-1:0] pending_first;
   logic [ANIM_WIDTH-1:0] pending_second;
   logic                  pend_first_valid;
   logic                  pend_second_valid;
   logic [ANIM_WIDTH-1:0] anim_value;
   logic [SEG_COUNT-1:0]  next_seg;
   logic [SLA_TOP_WIDTH:0] frames_seen;

   initial begin
      if (ANIM_WIDTH != 8 || SEG_COUNT < SLA_HIGH_BASE + ANIM_WIDTH) begin
         $error("Animator widths unsupported");
      end
   end

   // One-place barrel rotation
   function automatic logic [ANIM_WIDTH-1:0] rotate(input logic [ANIM_WIDTH-1:0] v, input sla_dir_e dir);
      if (dir == SLA_DIR_LEFT) begin
         rotate = {v[ANIM_WIDTH-2:0], v[ANIM_WIDTH-1]}; // R03
      end else begin
         rotate = {v[0], v[ANIM_WIDTH-1:1]}; // R03
      end
   endfunction : rotate

   sla_frame_counter #(
      .TOP_WIDTH (SLA_TOP_WIDTH)
   ) u_frame_counter (
      .clk        (CLK),
      .arst_n     (ARST_N),
      .frame_tick (FRAME_TICK),
      .enable     (CTRL.frame_counter_enable),
      .top        (CTRL.frame_counter_top),
      .overflow   (overflow)
   );

   // Writes are parked until the next frame so the shift cadence is untouched
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pending_first     <= SLA_PATTERN_RST;
         pend_first_valid  <= 1'b0;
         pending_second    <= SLA_PATTERN_RST;
         pend_second_valid <= 1'b0;
      end else begin
         if (PATTERN_FIRST_WE) begin
            pending_first    <= PATTERN_FIRST_DATA; // R10
            pend_first_valid <= 1'b1;
         end else if (FRAME_TICK) begin
            pend_first_valid <= 1'b0;
         end
         if (PATTERN_SECOND_WE) begin
            pending_second    <= PATTERN_SECOND_DATA; // R10
            pend_second_valid <= 1'b1;
         end else if (FRAME_TICK) begin
            pend_second_valid <= 1'b0;
         end
      end
   end

   // First array: loads at a frame, otherwise shifts on overflow
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PATTERN_FIRST <= SLA_PATTERN_RST;
      end else if (FRAME_TICK && pend_first_valid) begin
         PATTERN_FIRST <= pending_first; // R09
      end else if (overflow) begin
         PATTERN_FIRST <= rotate(PATTERN_FIRST, CTRL.dir_first); // R04
      end
   end

   // Second array, same scheme
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PATTERN_SECOND <= SLA_PATTERN_RST;
      end else if (FRAME_TICK && pend_second_valid) begin
         PATTERN_SECOND <= pending_second; // R09
      end else if (overflow) begin
         PATTERN_SECOND <= rotate(PATTERN_SECOND, CTRL.dir_second); // R04
      end
   end

   // Combine and place the animated ring
   always_comb begin
      anim_value = (CTRL.logic_function == SLA_FN_AND) ? (PATTERN_FIRST & PATTERN_SECOND)
                                                       : (PATTERN_FIRST | PATTERN_SECOND); // R02
      next_seg = SEG_DATA;
      if (CTRL.animation_enable) begin // R07
         if (CTRL.animation_location == SLA_LOC_UPPER) begin
            next_seg[SLA_HIGH_BASE +: ANIM_WIDTH] = anim_value; // R08
         end else begin
            next_seg[SLA_LOW_BASE +: ANIM_WIDTH] = anim_value; // R08
         end
      end
   end

   // Registered segment drive, runs with no software action
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SEG_OUT <= '0;
      end else begin
         SEG_OUT <= next_seg; // R01
      end
   end

   // Frames seen since the last overflow; feeds only the period check
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         frames_seen <= '0;
      end else if (!CTRL.frame_counter_enable) begin
         frames_seen <= '0;
      end else if (overflow) begin
         frames_seen <= {{SLA_TOP_WIDTH{1'b0}}, FRAME_TICK};
      end else if (FRAME_TICK) begin
         frames_seen <= (SLA_TOP_WIDTH + 1)'(frames_seen + 1'b1);
      end
   end

   a_seg_passthru: assert property (@(posedge CLK) disable iff (!ARST_N) // R07
      !$past(CTRL.animation_enable) |-> SEG_OUT == $past(SEG_DATA)) else $error("segments not ordinary data");

   a_upper_or: assert property (@(posedge CLK) disable iff (!ARST_N) // R02
      $past(CTRL.animation_enable) && $past(CTRL.animation_location) == SLA_LOC_UPPER
      && $past(CTRL.logic_function) == SLA_FN_OR
      |-> SEG_OUT[15:8] == ($past(PATTERN_FIRST) | $past(PATTERN_SECOND))) else $error("upper OR wrong");

   a_lower_and: assert property (@(posedge CLK) disable iff (!ARST_N) // R08
      $past(CTRL.animation_enable) && $past(CTRL.animation_location) == SLA_LOC_LOWER
      && $past(CTRL.logic_function) == SLA_FN_AND
      |-> SEG_OUT[7:0] == ($past(PATTERN_FIRST) & $past(PATTERN_SECOND))
          && SEG_OUT[15:8] == $past(SEG_DATA[15:8])) else $error("lower AND wrong");

   a_shift_left: assert property (@(posedge CLK) disable iff (!ARST_N) // R03
      overflow && !(FRAME_TICK && pend_first_valid) && CTRL.dir_first == SLA_DIR_LEFT
      |=> PATTERN_FIRST == {$past(PATTERN_FIRST[6:0]), $past(PATTERN_FIRST[7])}) else $error("left shift wrong");

   a_shift_right: assert property (@(posedge CLK) disable iff (!ARST_N) // R04
      overflow && !(FRAME_TICK && pend_second_valid) && CTRL.dir_second == SLA_DIR_RIGHT
      |=> PATTERN_SECOND == {$past(PATTERN_SECOND[0]), $past(PATTERN_SECOND[7:1])}) else $error("right shift wrong");

   a_hold_no_ovf: assert property (@(posedge CLK) disable iff (!ARST_N) // R01
      !overflow && !FRAME_TICK |=> $stable(PATTERN_FIRST) && $stable(PATTERN_SECOND)) else $error("array moved");

   // Deferred writes: captured at the strobe, applied at the next frame
   a_pend_first: assert property (@(posedge CLK) disable iff (!ARST_N) // R10
      PATTERN_FIRST_WE |=> pend_first_valid && pending_first == $past(PATTERN_FIRST_DATA))
      else $error("first write not captured");

   a_pend_second: assert property (@(posedge CLK) disable iff (!ARST_N) // R10
      PATTERN_SECOND_WE |=> pend_second_valid && pending_second == $past(PATTERN_SECOND_DATA))
      else $error("second write not captured");

   a_load_first: assert property (@(posedge CLK) disable iff (!ARST_N) // R10
      FRAME_TICK && pend_first_valid |=> PATTERN_FIRST == $past(pending_first))
      else $error("first write not applied at frame");

   a_load_second: assert property (@(posedge CLK) disable iff (!ARST_N) // R10
      FRAME_TICK && pend_second_valid |=> PATTERN_SECOND == $past(pending_second))
      else $error("second write not applied at frame");

   a_pend_retire: assert property (@(posedge CLK) disable iff (!ARST_N) // R10
      FRAME_TICK && !PATTERN_FIRST_WE |=> !pend_first_valid)
      else $error("first write left pending");

   a_pend_retire_second: assert property (@(posedge CLK) disable iff (!ARST_N) // R10
      FRAME_TICK && !PATTERN_SECOND_WE |=> !pend_second_valid)
      else $error("second write left pending");

   // Remaining direction pairs, so every array is seen turning both ways
   a_shift_first_right: assert property (@(posedge CLK) disable iff (!ARST_N) // R04
      overflow && !(FRAME_TICK && pend_first_valid) && CTRL.dir_first == SLA_DIR_RIGHT
      |=> PATTERN_FIRST == {$past(PATTERN_FIRST[0]), $past(PATTERN_FIRST[7:1])})
      else $error("first right shift wrong");

   a_shift_second_left: assert property (@(posedge CLK) disable iff (!ARST_N) // R03
      overflow && !(FRAME_TICK && pend_second_valid) && CTRL.dir_second == SLA_DIR_LEFT
      |=> PATTERN_SECOND == {$past(PATTERN_SECOND[6:0]), $past(PATTERN_SECOND[7])})
      else $error("second left shift wrong");

   // Other function and location pairings
   a_upper_and: assert property (@(posedge CLK) disable iff (!ARST_N) // R02
      $past(CTRL.animation_enable) && $past(CTRL.animation_location) == SLA_LOC_UPPER
      && $past(CTRL.logic_function) == SLA_FN_AND
      |-> SEG_OUT[15:8] == ($past(PATTERN_FIRST) & $past(PATTERN_SECOND)))
      else $error("upper AND wrong");

   a_lower_or: assert property (@(posedge CLK) disable iff (!ARST_N) // R02
      $past(CTRL.animation_enable) && $past(CTRL.animation_location) == SLA_LOC_LOWER
      && $past(CTRL.logic_function) == SLA_FN_OR
      |-> SEG_OUT[7:0] == ($past(PATTERN_FIRST) | $past(PATTERN_SECOND)))
      else $error("lower OR wrong");

   a_upper_keeps_low: assert property (@(posedge CLK) disable iff (!ARST_N) // R08
      $past(CTRL.animation_enable) && $past(CTRL.animation_location) == SLA_LOC_UPPER
      |-> SEG_OUT[7:0] == $past(SEG_DATA[7:0]))
      else $error("lower group disturbed");

   // A lowered top may stretch one period, so only early overflow is refused
   a_ovf_period: assert property (@(posedge CLK) disable iff (!ARST_N) // R05
      overflow |-> frames_seen > {1'b0, $past(CTRL.frame_counter_top)})
      else $error("overflow before top frames");

   a_ovf_enabled: assert property (@(posedge CLK) disable iff (!ARST_N) // R06
      !CTRL.frame_counter_enable |=> !overflow) else $error("overflow while disabled");

endmodule : sla_animator

// ===== inc/sla_pkg.sv
// Package of constants and carriers for the segment LCD animator
//
// Behaviour
// R01: Animate up to eight segments autonomously, no processor action after setup.
// R02: Each animated segment shows AND or OR of its bits in both arrays.
// R03: On each frame counter overflow both arrays barrel-shift one place, wrapping; an array loads its pending write instead if FRAME_TICK is high then.
// R04: Shift direction of each array is selectable, left or right.
// R05: Frame counter overflows after a programmed number of frames, the top field.
// R06: Frame counter counts and overflows only while its enable bit is set.
// R07: Animated values reach the segments only while animation is enabled.
// R08: Location setting picks the animated group; one setting uses segments 8 to 15.
// R09: Software loads both patterns and configures control before relying on animation.
// R10: Arrays hold eight bits; software writes take effect at next frame, timing kept.
package sla_pkg;

   localparam int                SLA_ANIM_WIDTH   = 8;
   localparam int                SLA_SEG_COUNT    = 16;
   localparam int                SLA_TOP_WIDTH    = 6;
   localparam int                SLA_LOW_BASE     = 0;
   localparam int                SLA_HIGH_BASE    = 8;
   localparam logic [7:0]        SLA_PATTERN_RST  = 8'h00;
   localparam logic [5:0]        SLA_COUNT_RST    = 6'h00;

   // Shift direction codes
   typedef enum logic { SLA_DIR_LEFT, SLA_DIR_RIGHT } sla_dir_e;

   // Animation location codes
   typedef enum logic { SLA_LOC_LOWER, SLA_LOC_UPPER } sla_loc_e;

   // Combining function codes
   typedef enum logic { SLA_FN_AND, SLA_FN_OR } sla_fn_e;

   // Control bits written by software
   typedef struct packed {
      logic       frame_counter_enable;
      logic [5:0] frame_counter_top;
      logic       animation_enable;
      sla_fn_e    logic_function;
      sla_dir_e   dir_first;
      sla_dir_e   dir_second;
      sla_loc_e   animation_location;
   } sla_ctrl_s;

endpackage : sla_pkg

// ===== hdl/sla_frame_counter.sv
// Frame counter producing a one-cycle overflow pulse
`timescale 1ns/1ps
module sla_frame_counter
   import sla_pkg::*;
#(
   parameter int TOP_WIDTH = SLA_TOP_WIDTH
)(
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic                 frame_tick,
   input  wire logic                 enable,
   input  wire logic [TOP_WIDTH-1:0] top,
   output logic                      overflow
);

   logic [TOP_WIDTH-1:0] count;

   initial begin
      if (TOP_WIDTH < 1 || TOP_WIDTH > 16) begin
         $error("TOP_WIDTH out of range");
      end
   end

   // Counts top+1 frames per overflow; cleared while disabled
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count    <= TOP_WIDTH'(SLA_COUNT_RST);
         overflow <= 1'b0;
      end else begin
         overflow <= 1'b0;
         if (!enable) begin
            count <= TOP_WIDTH'(SLA_COUNT_RST); // R06
         end else if (frame_tick) begin
            if (count >= top) begin
               count    <= '0; // R05
               overflow <= 1'b1; // R05
            end else begin
               count <= TOP_WIDTH'(count + 1'b1);
            end
         end
      end
   end

   a_no_ovf_disabled: assert property (@(posedge clk) disable iff (!arst_n) // R06
      overflow |-> $past(enable)) else $error("overflow while counter disabled");

   a_ovf_needs_tick: assert property (@(posedge clk) disable iff (!arst_n) // R05
      overflow |-> $past(frame_tick) && $past(count) >= $past(top)) else $error("overflow without top reached");

endmodule : sla_frame_counter

// ===== tb/sla_lcd_panel.sv
// Segment panel model that latches the drive once per frame
`timescale 1ns/1ps
module sla_lcd_panel
   import sla_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     arst_n,
   input  wire logic                     frame_tick,
   input  wire logic [SLA_SEG_COUNT-1:0] seg,
   output logic      [SLA_SEG_COUNT-1:0] shown
);
   // Glass refreshes only at frame edges, so mid-frame glitches never show
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) shown <= '0;
      else if (frame_tick) shown <= seg;
   end
endmodule : sla_lcd_panel

// ===== tb/test_sla_animator.sv
// Self-checking bench for the segment animator
`timescale 1ns/1ps
module test_sla_animator
   import sla_pkg::*;
;
   typedef struct packed {logic [15:0] seg; logic [7:0] pa; logic [7:0] pb; logic [15:0] gl;} sla_note_s;
   logic        clk = 0, arst_n = 0, tick = 0, we_a = 0, we_b = 0, look = 0;
   sla_ctrl_s   ctrl = '0;
   logic [7:0]  da = 8'h00, db = 8'h00, pa = 8'h00, pb = 8'h00, pf, ps;
   logic [15:0] seg_data = 16'h0000, seg_out, shown, glass = 16'h0000, last_seg = 16'h0000;
   logic [31:0] lfsr = 32'h7a7b5039;
   int          num_errors = 0, checked = 0, cnt = 0;
   sla_note_s   notes[$];
   sla_note_s   n;
   // Half period of a 100 ns clock
   always #50 clk = ~clk;
   sla_animator i_dut (.CLK(clk), .ARST_N(arst_n), .FRAME_TICK(tick), .CTRL(ctrl),
      .PATTERN_FIRST_DATA(da), .PATTERN_FIRST_WE(we_a), .PATTERN_SECOND_DATA(db),
      .PATTERN_SECOND_WE(we_b), .SEG_DATA(seg_data), .SEG_OUT(seg_out),
      .PATTERN_FIRST(pf), .PATTERN_SECOND(ps));
   sla_lcd_panel i_panel (.clk(clk), .arst_n(arst_n), .frame_tick(tick), .seg(seg_out), .shown(shown));
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand
   // Left rotation carries bit 7 round to bit 0
   function automatic logic [7:0] rot(input logic [7:0] p, input sla_dir_e d);
      return (d == SLA_DIR_LEFT) ? {p[6:0], p[7]} : {p[0], p[7:1]};
   endfunction : rot
   task automatic chk(input logic [15:0] seen, input logic [15:0] want, input string what);
      checked++;
      if (seen !== want) begin
         num_errors++;
         $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, want);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc
   // One frame pulse; overflow and rotation land within the four idle cycles
   task automatic tick_once();
      glass = last_seg;
      tick = 1;
      cyc(1);
      tick = 0;
      cyc(4);
      if (!ctrl.frame_counter_enable) cnt = 0;
      else if (cnt >= int'(ctrl.frame_counter_top)) begin
         pa = rot(pa, ctrl.dir_first);
         pb = rot(pb, ctrl.dir_second);
         cnt = 0;
      end else cnt++;
   endtask : tick_once
   task automatic expect_now();
      sla_note_s e;
      int base;
      cyc(2);
      base = (ctrl.animation_location == SLA_LOC_UPPER) ? 8 : 0;
      e.pa = pa;
      e.pb = pb;
      e.seg = seg_data;
      if (ctrl.animation_enable) e.seg[base +: 8] = (ctrl.logic_function == SLA_FN_OR) ? (pa | pb) : (pa & pb);
      e.gl = glass;
      last_seg = e.seg;
      notes.push_back(e);
      look = 1;
      cyc(1);
      look = 0;
   endtask : expect_now
   // Writes stay pending until the next frame pulse
   task automatic load(input logic [7:0] a, input logic [7:0] b);
      {we_a, we_b, da, db} = {2'b11, a, b};
      cyc(1);
      {we_a, we_b, da, db} = {2'b00, ~a, ~b};
      expect_now();
      tick_once();
      pa = a;
      pb = b;
      expect_now();
   endtask : load
   // Oldest note is compared whenever a sample is strobed
   always @(posedge clk) begin
      if (look && notes.size() == 0) begin
         num_errors++;
         $display("[FAIL] %0t sample without note", $time);
      end else if (look) begin
         n = notes.pop_front();
         chk(seg_out, n.seg, "segments");
         chk({8'h00, pf}, {8'h00, n.pa}, "first array");
         chk({8'h00, ps}, {8'h00, n.pb}, "second array");
         chk(shown, n.gl, "panel");
      end
   end
   task automatic summarize();
      $display("checked %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize
   // Watchdog against a hung run
   initial begin
      #3000000;
      num_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      summarize();
   end
   initial begin
      cyc(8);
      arst_n = 1;
      expect_now();
      lfsr = next_rand(lfsr);
      load(lfsr[23:16], lfsr[31:24]);
      for (int i = 0; i < 8; i++) begin
         lfsr = next_rand(lfsr);
         seg_data = lfsr[15:0];
         ctrl.logic_function = sla_fn_e'(i[0]);
         ctrl.animation_location = sla_loc_e'(i[1]);
         ctrl.animation_enable = i[2];
         expect_now();
      end
      $display("test combine done");
      load(8'h13, 8'hc8);
      repeat (3) tick_once();
      expect_now();
      for (int d = 0; d < 4; d++) begin
         {ctrl.dir_first, ctrl.dir_second} = {sla_dir_e'(d[0]), sla_dir_e'(d[1])};
         ctrl.frame_counter_top = 6'(d);
         ctrl.frame_counter_enable = 1;
         cnt = 0;
         repeat (d + 2) begin
            tick_once();
            expect_now();
         end
         ctrl.frame_counter_enable = 0;
         cyc(2);
      end
      $display("test shift done");
      summarize();
   end
endmodule : test_sla_animator
